/* File: rtl/ebcc_consts.vh */
`ifndef EBCC_CONSTS_VH
`define EBCC_CONSTS_VH
// on-chip rom window bounds
`define EBCC_ROM_LO 16'h2000
`define EBCC_ROM_HI 16'h2FFF
// cycle phase states
`define EBCC_ST_IDLE 2'h0
`define EBCC_ST_ADDR 2'h1
`define EBCC_ST_DATA 2'h2
// access kinds
`define EBCC_KIND_DATA 2'h0
`define EBCC_KIND_FETCH 2'h1
`define EBCC_KIND_VECT 2'h2
`define EBCC_KIND_CCR 2'h3
// edges spent filling the pin synchronisers before strap capture
`define EBCC_SETTLE_CNT 2'h2
// width of the programming mode select field
`define EBCC_PMODE_W 4
`endif

/* File: rtl/ebcc_bus_ctrl.v */
`timescale 1ns/1ps
// Notes on behaviour
// - high byte enable low in 16-bit cycles for word and high-byte access
// - enable and addr_lsb: 00 both, 01 high only, 10 low only
// - dynamic width enabled: sample width input, high 16-bit, low 8-bit
// - width input honoured also while fetching chip configuration value
// - fetch indicator high through whole external instruction fetch cycle
// - fetch indicator low for data, vector, config reads, internal fetches
// - strap low: all accesses go to external memory
// - strap high: 2000H-2FFFH on-chip, everything else external
// - strap captured only at reset release, held until next reset
// - strap at programming level: enter mode from prog_mode_select
// - isolate input low at reset release: all pins high impedance
// - isolation left only by reset
module ebcc_bus_ctrl
(
    input wire clock_i,                        // system clock
    input wire rst_b_i,                        // async reset, active low
    input wire ce_i,                           // clock enable
    input wire memory_source_strap_n_i,        // pin, strap level
    input wire programming_level_i,            // pin, strap at prog level
    input wire [3:0] prog_mode_select_i,       // pin, prog mode select
    input wire isolate_n_i,                    // pin, emulation isolate
    input wire dynamic_width_select_i,         // pin, 1 = 16-bit cycle
    input wire dyn_width_en_i,                 // config: dynamic width on
    input wire cfg_wide_i,                     // config: fixed 16-bit bus
    input wire req_i,                          // core access request
    input wire [15:0] req_addr_i,              // access address
    input wire req_word_i,                     // word access
    input wire [1:0] req_kind_i,               // data/fetch/vector/config
    output reg busy_o,                         // cycle in progress
    output reg done_o,                         // access complete pulse
    output reg internal_o,                     // last access went on-chip
    output reg wide_o,                         // last cycle was 16-bit
    output reg addr_valid_n_o,                 // address valid strobe
    output reg addr_valid_n_oe_o,              // its output enable
    output reg high_byte_enable_n_o,           // high byte enable
    output reg high_byte_enable_n_oe_o,        // its output enable
    output reg [15:0] ad_o,                    // address on ad bus
    output reg ad_oe_o,                        // ad bus output enable
    output reg fetch_indicator_o,              // instruction fetch flag
    output reg fetch_indicator_oe_o,           // its output enable
    output reg isolated_o,                     // isolation mode active
    output reg prog_mode_o,                    // programming mode active
    output reg [3:0] prog_mode_sel_o,          // latched programming mode
    output reg strap_ext_only_o                // latched strap: external only
);
`include "ebcc_consts.vh"

// ----------------------------------------------------------------
// pin synchronisers
// ----------------------------------------------------------------
reg [1:0] sync_strap;
reg [1:0] sync_plvl;
reg [1:0] sync_iso;
reg [1:0] sync_bw;
reg [3:0] sync_pm0;
reg [3:0] sync_pm1;

// two flops per pin input
always @(posedge clock_i or negedge rst_b_i)
begin
    if (!rst_b_i)
    begin
        sync_strap <= 2'h0;
        sync_plvl <= 2'h0;
        sync_iso <= 2'h3;
        sync_bw <= 2'h0;
        sync_pm0 <= 4'h0;
        sync_pm1 <= 4'h0;
    end
    else if (ce_i)
    begin
        sync_strap <= {sync_strap[0], memory_source_strap_n_i};
        sync_plvl <= {sync_plvl[0], programming_level_i};
        sync_iso <= {sync_iso[0], isolate_n_i};
        sync_bw <= {sync_bw[0], dynamic_width_select_i};
        // prog mode select moves as a bus through two stages
        sync_pm0 <= prog_mode_select_i;
        sync_pm1 <= sync_pm0;
    end
end

// ----------------------------------------------------------------
// strap capture at reset release
// ----------------------------------------------------------------
reg strap_taken;
// counts edges while the pin synchronisers fill
reg [1:0] settle;

// hazard: the synchronisers still hold their reset values on the
// first edges after release, so capture waits until they have filled
always @(posedge clock_i or negedge rst_b_i)
begin
    if (!rst_b_i)
    begin
        settle <= 2'h0;
        strap_taken <= 1'b0;
        strap_ext_only_o <= 1'b1;
        isolated_o <= 1'b0;
        prog_mode_o <= 1'b0;
        prog_mode_sel_o <= 4'h0;
    end
    else if (ce_i && !strap_taken)
    begin
        if (settle != `EBCC_SETTLE_CNT)
            settle <= settle + 2'h1;
        else
        begin
            strap_taken <= 1'b1;
            strap_ext_only_o <= !sync_strap[1];
            prog_mode_o <= sync_plvl[1];
            prog_mode_sel_o <= sync_pm1;
            isolated_o <= !sync_iso[1];
        end
    end
end

// ----------------------------------------------------------------
// address steering and width decode
// ----------------------------------------------------------------
function is_onchip;
    input [15:0] a;
    input ext_only;
    begin
        is_onchip = !ext_only && (a >= `EBCC_ROM_LO) &&
            (a <= `EBCC_ROM_HI);
    end
endfunction

// a request is taken only when idle, strapped, not isolated and not in programming mode
wire go = req_i && !busy_o && strap_taken && !isolated_o && !prog_mode_o;
// on-chip window check uses the latched strap
wire on_chip = is_onchip(req_addr_i, strap_ext_only_o);
// width: dynamic input also applies to config fetch
wire wide_now = dyn_width_en_i ? sync_bw[1] : cfg_wide_i;

// ----------------------------------------------------------------
// bus cycle sequencer
// ----------------------------------------------------------------
reg [1:0] state;
reg [15:0] cur_addr;
reg cur_word;

always @(posedge clock_i or negedge rst_b_i)
begin
    if (!rst_b_i)
    begin
        state <= `EBCC_ST_IDLE;
        cur_addr <= 16'h0000;
        cur_word <= 1'b0;
        busy_o <= 1'b0;
        done_o <= 1'b0;
        internal_o <= 1'b0;
        wide_o <= 1'b0;
        addr_valid_n_o <= 1'b1;
        high_byte_enable_n_o <= 1'b1;
        ad_o <= 16'h0000;
        ad_oe_o <= 1'b0;
        fetch_indicator_o <= 1'b0;
        addr_valid_n_oe_o <= 1'b0;
        high_byte_enable_n_oe_o <= 1'b0;
        fetch_indicator_oe_o <= 1'b0;
    end
    else if (ce_i)
    begin
        done_o <= 1'b0;
        // pins float while isolated or before straps are taken
        addr_valid_n_oe_o <= strap_taken && !isolated_o;
        high_byte_enable_n_oe_o <= strap_taken && !isolated_o;
        fetch_indicator_oe_o <= strap_taken && !isolated_o;
        case (state)
        `EBCC_ST_IDLE:
        begin
            // on-chip access completes at once
            if (go && on_chip)
            begin
                internal_o <= 1'b1;    // no strobes
                fetch_indicator_o <= 1'b0;
                done_o <= 1'b1;
            end
            else if (go)
            begin
                internal_o <= 1'b0;
                busy_o <= 1'b1;
                cur_addr <= req_addr_i;
                cur_word <= req_word_i;
                ad_o <= req_addr_i;
                ad_oe_o <= 1'b1;
                addr_valid_n_o <= 1'b0;
                fetch_indicator_o <= (req_kind_i == `EBCC_KIND_FETCH);
                state <= `EBCC_ST_ADDR;
            end
        end
        `EBCC_ST_ADDR:
        begin
            wide_o <= wide_now;
            // byte lanes: 00 both, 01 high, 10 low
            high_byte_enable_n_o <= !(wide_now &&
                (cur_word || cur_addr[0]));
            ad_oe_o <= 1'b0;
            state <= `EBCC_ST_DATA;
        end
        `EBCC_ST_DATA:
        begin
            // end of cycle: strobes high, done pulse
            addr_valid_n_o <= 1'b1;
            high_byte_enable_n_o <= 1'b1;
            fetch_indicator_o <= 1'b0;
            busy_o <= 1'b0;
            done_o <= 1'b1;
            state <= `EBCC_ST_IDLE;
        end
        default:
            state <= `EBCC_ST_IDLE;
        endcase
    end
end

endmodule // ebcc_bus_ctrl

/* File: verif/ebcc_bus_ctrl_monitor.sv */
`timescale 1ns/1ps
module ebcc_mon
(
    input wire clock_i, rst_b_i, ce_i, done_o, internal_o, wide_o,
    input wire addr_valid_n_o, addr_valid_n_oe_o, high_byte_enable_n_o,
    input wire ad_oe_o, fetch_indicator_o, isolated_o, prog_mode_o,
    input wire strap_ext_only_o,
    input wire [1:0] req_kind_i,
    input wire [15:0] ad_o
);
    default clocking @(posedge clock_i iff ce_i); endclocking
    default disable iff (!rst_b_i);
    property p_adv; $fell(addr_valid_n_o) |=>
        !addr_valid_n_o ##1 addr_valid_n_o && done_o; endproperty
    a_adv: assert property (p_adv) else $error("strobe shape");
    property p_hbe; !high_byte_enable_n_o |-> wide_o && !addr_valid_n_o;
    endproperty
    a_hbe: assert property (p_hbe) else $error("hbe in narrow");
    property p_kind; $fell(addr_valid_n_o) |->
        fetch_indicator_o == ($past(req_kind_i) == 2'h1); endproperty
    a_kind: assert property (p_kind) else $error("fetch kind");
    property p_fwin; $rose(fetch_indicator_o) |=>
        fetch_indicator_o ##1 !fetch_indicator_o; endproperty
    a_fwin: assert property (p_fwin) else $error("fetch span");
    property p_fext; fetch_indicator_o |-> !addr_valid_n_o; endproperty
    a_fext: assert property (p_fext) else $error("fetch idle");
    property p_rom; $fell(addr_valid_n_o) |-> strap_ext_only_o ||
        ad_o < 16'h2000 || ad_o > 16'h2FFF; endproperty
    a_rom: assert property (p_rom) else $error("rom went out");
    property p_int; done_o && internal_o |->
        $past(addr_valid_n_o) && high_byte_enable_n_o; endproperty
    a_int: assert property (p_int) else $error("onchip strobe");
    property p_iso; isolated_o |=> isolated_o && !ad_oe_o &&
        !addr_valid_n_oe_o; endproperty
    a_iso: assert property (p_iso) else $error("isolation");
    property p_prog; prog_mode_o |-> addr_valid_n_o; endproperty
    a_prog: assert property (p_prog) else $error("prog bus");
    c_fetch: cover property ($rose(fetch_indicator_o));
    c_int: cover property (done_o && internal_o);
    c_iso: cover property ($rose(isolated_o));
endmodule // ebcc_mon
bind ebcc_bus_ctrl ebcc_mon u_ebcc_mon(.*);

/* File: verif/ebcc_mem.sv */
`timescale 1ns/1ps
module ebcc_mem
(
    input wire clock_i,               // system clock
    input wire addr_valid_n_o,        // address valid strobe
    input wire ad_oe_o,               // address phase
    input wire [15:0] ad_o,           // ad bus
    input wire high_byte_enable_n_o,  // high byte enable
    output reg [15:0] lat_addr,       // latched address
    output reg lat_hbe,               // lane select seen
    output reg [7:0] cycles           // external cycles seen
);
    initial cycles = 8'h00;
    // address latch, then byte lane decode in data phase
    always @(posedge clock_i)
    begin
        if (!addr_valid_n_o && ad_oe_o)
        begin
            lat_addr <= ad_o;
            cycles <= cycles + 8'h01;
        end
        if (!addr_valid_n_o && !ad_oe_o)
            lat_hbe <= high_byte_enable_n_o;
    end
endmodule // ebcc_mem

/* File: verif/ebcc_bus_ctrl_tb.sv */
`timescale 1ns/1ps
module ebcc_bus_ctrl_tb;
    reg clock_i = 0, rst_b_i = 0, ce_i = 1, memory_source_strap_n_i = 0;
    reg programming_level_i = 0, isolate_n_i = 1, dynamic_width_select_i = 1;
    reg dyn_width_en_i = 1, cfg_wide_i = 0, req_i = 0, req_word_i = 0;
    reg [3:0] prog_mode_select_i = 4'h0;
    reg [15:0] req_addr_i = 16'h0000;
    reg [1:0] req_kind_i = 2'h0;
    wire busy_o, done_o, internal_o, wide_o, addr_valid_n_o, ad_oe_o;
    wire addr_valid_n_oe_o, high_byte_enable_n_o, high_byte_enable_n_oe_o;
    wire fetch_indicator_o, fetch_indicator_oe_o, isolated_o, prog_mode_o;
    wire strap_ext_only_o, lat_hbe;
    wire [15:0] ad_o, lat_addr;
    wire [3:0] prog_mode_sel_o;
    wire [7:0] cycles;
    integer errors = 0, compares = 0;
    ebcc_bus_ctrl u_ebcc_bus_ctrl(.*);
    ebcc_mem u_ebcc_mem(.*);
    initial forever #2 clock_i = ~clock_i;
    task chk(input ok, input [63:0] msg);
        compares++;
        if (!ok) begin errors++; $display("ERROR %0t %0s", $time, msg); end
    endtask
    task rst(input s, input p, input i);
        {memory_source_strap_n_i, programming_level_i, isolate_n_i} = {s, p, i};
        rst_b_i = 0;
        repeat (3) @(posedge clock_i);
        #1 rst_b_i = 1;
        repeat (5) @(posedge clock_i);
        #1;
    endtask
    task acc(input [15:0] a, input w, input [1:0] k, input ei, input ew);
        integer n;
        reg [7:0] c0;
        c0 = cycles; n = 0;
        {req_addr_i, req_word_i, req_kind_i, req_i} = {a, w, k, 1'b1};
        do begin @(posedge clock_i); #1 n++; end while (!done_o && n < 10);
        req_i = 0;
        chk(done_o === 1'b1 && internal_o === ei, "route");
        chk(cycles === c0 + (ei ? 8'h00 : 8'h01), "strobes");
        if (!ei) chk(lat_addr === a && wide_o === ew, "addr");
        if (!ei) chk(lat_hbe === !(ew && (w || a[0])), "lanes");
    endtask
    task t_ext;
        rst(0, 0, 1);
        acc(16'h2100, 1, 1, 0, 1);
        acc(16'h0101, 0, 2, 0, 1);
        acc(16'h0100, 0, 0, 0, 1);
        memory_source_strap_n_i = 1; repeat (4) @(posedge clock_i); #1;
        chk(strap_ext_only_o === 1'b1, "strap");
        acc(16'h2000, 1, 0, 0, 1);
        $display("t_ext done");
    endtask
    task t_rom;
        rst(1, 0, 1);
        acc(16'h2000, 1, 1, 1, 0);
        acc(16'h2FFF, 0, 0, 1, 0);
        acc(16'h3000, 1, 1, 0, 1);
        acc(16'h1FFF, 0, 0, 0, 1);
        $display("t_rom done");
    endtask
    task t_width;
        rst(0, 0, 1); dynamic_width_select_i = 0;
        repeat (3) @(posedge clock_i); #1;
        acc(16'h4000, 1, 3, 0, 0);
        {dyn_width_en_i, cfg_wide_i} = 2'b01;
        acc(16'h4002, 1, 0, 0, 1);
        {dyn_width_en_i, cfg_wide_i, dynamic_width_select_i} = 3'b101;
        req_addr_i = 16'h4100; req_kind_i = 2'h0; req_i = 1;
        @(posedge clock_i); #1 ce_i = 0; req_i = 0;
        repeat (4) @(posedge clock_i); #1;
        chk(busy_o === 1'b1 && done_o === 1'b0 &&
            addr_valid_n_o === 1'b0, "freeze");
        ce_i = 1; repeat (2) @(posedge clock_i); #1;
        chk(done_o === 1'b1 && busy_o === 1'b0, "thaw");
        $display("t_width done");
    endtask
    task t_iso;
        rst(0, 0, 0); req_i = 1; repeat (6) @(posedge clock_i); #1;
        chk(busy_o === 1'b0 && isolated_o === 1'b1 && !ad_oe_o, "iso");
        chk(addr_valid_n_oe_o === 1'b0 && fetch_indicator_oe_o === 1'b0 &&
            high_byte_enable_n_oe_o === 1'b0, "iso oe");
        req_i = 0; rst(0, 0, 1);
        chk(isolated_o === 1'b0, "iso exit");
        chk(addr_valid_n_oe_o === 1'b1 && fetch_indicator_oe_o === 1'b1 &&
            high_byte_enable_n_oe_o === 1'b1, "oe back");
        prog_mode_select_i = 4'hA; rst(0, 1, 1);
        chk(prog_mode_o === 1'b1 && prog_mode_sel_o === 4'hA, "pmode");
        $display("t_iso done");
    endtask
    task close_out;
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin t_ext; t_rom; t_width; t_iso; close_out; end
    initial begin #20000; errors++; close_out; end
endmodule // ebcc_bus_ctrl_tb
